//--- hw/card_end.sv
// card end of the parallel port: read strobe, acknowledge, DMA request
module card_end #(
  parameter int DATA_W = cardio_pkg::DATA_W,
  parameter int ADDR_W = cardio_pkg::ADDR_W,
  parameter int FIFO_DEPTH = cardio_pkg::FIFO_DEPTH,
  parameter int CNT_W = cardio_pkg::CNT_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  card_bus_if.card bus,
  input wire cardio_pkg::card_mode_t card_mode,
  input wire logic dev_selected,
  input wire logic [DATA_W-1:0] reg_rdata,
  output logic [ADDR_W-1:0] reg_addr,
  output logic reg_wr_valid,
  output logic [DATA_W-1:0] reg_wr_data,
  input wire logic dma_start,
  input wire logic dma_to_host,
  input wire logic [CNT_W-1:0] dma_words,
  output logic dma_busy,
  input wire logic rd_valid,
  input wire logic [DATA_W-1:0] rd_data,
  output logic rd_taken,
  output logic wr_valid,
  output logic [DATA_W-1:0] wr_data,
  input wire logic wr_ready
);
  localparam int SW = 6 + ADDR_W + DATA_W;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_GAP = 4'h2,
    S_REQ = 4'h4,
    S_MOVE = 4'h8
  } dma_state_t;

  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic rd_s;
  logic wr_s;
  logic ce_s;
  logic tfs_s;
  logic cbs_s;
  logic grant_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] data_s;
  logic rd_prev_reg;
  logic wr_prev_reg;
  logic rd_end;
  logic wr_end;
  logic io_active;
  logic reg_hit;
  logic dma_read_now;
  logic read_now;
  dma_state_t state_reg;
  logic dir_to_host_reg;
  logic [CNT_W-1:0] remain_reg;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic dma_ready;

  // every pin passes two flops; only stage two is read below
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= {6'h3F, {ADDR_W{1'b0}}, {DATA_W{1'b1}}};
      sync2_reg <= {6'h3F, {ADDR_W{1'b0}}, {DATA_W{1'b1}}};
    end else begin
      sync1_reg <= {bus.io_read_strobe_n, bus.io_write_strobe_n, bus.card_enable_n,
                    bus.task_file_select_n, bus.control_block_select_n,
                    bus.dma_grant_line_n, bus.addr, bus.data_bus};
      sync2_reg <= sync1_reg;
    end
  end

  assign rd_s = ~sync2_reg[SW-1];
  assign wr_s = ~sync2_reg[SW-2];
  assign ce_s = ~sync2_reg[SW-3];
  assign tfs_s = ~sync2_reg[SW-4];
  assign cbs_s = ~sync2_reg[SW-5];
  assign grant_s = ~sync2_reg[SW-6];
  assign addr_s = sync2_reg[DATA_W +: ADDR_W];
  assign data_s = sync2_reg[DATA_W-1:0];

  // strobe history for trailing edge detection
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b0;
    end else begin
      rd_prev_reg <= rd_s;
      wr_prev_reg <= wr_s;
    end
  end

  assign rd_end = rd_prev_reg & ~rd_s;
  assign wr_end = wr_prev_reg & ~wr_s;

  // memory mode leaves both strobes without effect
  assign io_active = (card_mode == cardio_pkg::MODE_IO) ||
                     (card_mode == cardio_pkg::MODE_DISK);
  assign reg_hit = (card_mode == cardio_pkg::MODE_IO) ? ce_s : (tfs_s | cbs_s);
  assign dma_read_now = (state_reg == S_MOVE) & dir_to_host_reg & grant_s;
  assign read_now = io_active & rd_s & (reg_hit | dma_read_now);

  // read data onto the bus only while the read strobe is held
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus.data_card_oe <= 1'b0;
      bus.data_card <= '0;
    end else begin
      bus.data_card_oe <= read_now;
      if (dma_read_now) begin
        bus.data_card <= rd_data;
      end else if (card_mode == cardio_pkg::MODE_DISK) begin
        bus.data_card <= reg_rdata & cardio_pkg::BYTE_MASK;
      end else begin
        bus.data_card <= reg_rdata;
      end
    end
  end

  // acknowledge only for a selected I/O read in card I/O mode
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus.input_acknowledge_n <= 1'b1;
    end else begin
      bus.input_acknowledge_n <= ~((card_mode == cardio_pkg::MODE_IO) &
                                   ce_s & rd_s);
    end
  end

  // register writes land on the trailing edge of the write strobe
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_addr <= '0;
      reg_wr_valid <= 1'b0;
      reg_wr_data <= '0;
    end else begin
      reg_addr <= addr_s;
      reg_wr_valid <= io_active & wr_end & reg_hit & ~grant_s;
      if (card_mode == cardio_pkg::MODE_DISK) begin
        reg_wr_data <= data_s & cardio_pkg::BYTE_MASK;
      end else begin
        reg_wr_data <= data_s;
      end
    end
  end

  // host-to-card DMA words; a full fifo holds back the next request
  assign fifo_in_valid = (state_reg == S_MOVE) & ~dir_to_host_reg & grant_s &
                         wr_end;
  assign dma_ready = dir_to_host_reg ? rd_valid : fifo_in_ready;

  stream_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(data_s),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(wr_data)
  );

  // one request per word; the grant must drop before the next one
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= S_IDLE;
      dir_to_host_reg <= 1'b0;
      remain_reg <= '0;
      rd_taken <= 1'b0;
    end else begin
      rd_taken <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (dma_start && card_mode == cardio_pkg::MODE_DISK) begin
            dir_to_host_reg <= dma_to_host;
            remain_reg <= dma_words;
            state_reg <= S_GAP;
          end
        end
        S_GAP: begin
          if (remain_reg == '0) begin
            state_reg <= S_IDLE;
          end else if (!grant_s && dma_ready) begin
            state_reg <= S_REQ;
          end
        end
        S_REQ: begin
          if (grant_s) begin
            state_reg <= S_MOVE;
          end
        end
        S_MOVE: begin
          if (grant_s && (dir_to_host_reg ? rd_end : wr_end)) begin
            remain_reg <= remain_reg - 1'b1;
            rd_taken <= dir_to_host_reg;
            state_reg <= S_GAP;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  // request lags state by one cycle; driven only for the selected device
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus.dma_request_line <= 1'b0;
      bus.dma_request_oe <= 1'b0;
      dma_busy <= 1'b0;
    end else begin
      bus.dma_request_line <= (state_reg == S_REQ) | (state_reg == S_MOVE);
      bus.dma_request_oe <= (card_mode == cardio_pkg::MODE_DISK) & dev_selected;
      dma_busy <= (state_reg != S_IDLE);
    end
  end
endmodule

//--- hw/cardio_pkg.sv
// shared constants and types for the card parallel port ends
// Operation
// - input acknowledge only for selected I/O reads
// - host gates read data with input acknowledge
// - raise DMA request when ready to move data
// - host picks direction by read or write strobe
// - hold DMA request until grant is seen
// - request again while words remain
// - request line undriven when not selected device
// - host keeps both selects negated during DMA
// - DMA transfers use full sixteen bit bus
// - host generates the I/O read strobe
// - card drives data only during read strobe
// - memory mode ignores the I/O read strobe
// - disk mode treats read strobe like I/O
// - register bytes on low lines, data sixteen
// - write data captured on strobe trailing edge
package cardio_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 16;
  localparam int CLK_NS = 40;
  // least times, rounded up to whole cycles
  localparam int SETUP_NS = 80;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_NS = 320;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_NS = 120;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] BYTE_MASK = 16'h00FF;
  localparam logic [15:0] BUS_IDLE = 16'hFFFF;

  typedef enum logic [1:0] {
    MODE_MEMORY = 2'h0,
    MODE_IO = 2'h1,
    MODE_DISK = 2'h2
  } card_mode_t;

  typedef enum logic [1:0] {
    CMD_REG_RD = 2'h0,
    CMD_REG_WR = 2'h1,
    CMD_DMA_RD = 2'h2,
    CMD_DMA_WR = 2'h3
  } host_cmd_t;
endpackage

//--- hw/card_bus_if.sv
// parallel card port wires between host end and card end
interface card_bus_if;
  logic io_read_strobe_n;
  logic io_write_strobe_n;
  logic card_enable_n;
  logic task_file_select_n;
  logic control_block_select_n;
  logic dma_grant_line_n;
  logic [cardio_pkg::ADDR_W-1:0] addr;
  logic [cardio_pkg::DATA_W-1:0] data_host;
  logic data_host_oe;
  logic [cardio_pkg::DATA_W-1:0] data_card;
  logic data_card_oe;
  logic input_acknowledge_n;
  logic dma_request_line;
  logic dma_request_oe;
  logic [cardio_pkg::DATA_W-1:0] data_bus;
  logic dma_request_seen;

  // bus resolution: undriven data floats high, undriven request reads low
  assign data_bus = data_card_oe ? data_card :
                    (data_host_oe ? data_host : cardio_pkg::BUS_IDLE);
  assign dma_request_seen = dma_request_oe & dma_request_line;

  modport host (
    output io_read_strobe_n, io_write_strobe_n, card_enable_n,
    output task_file_select_n, control_block_select_n, dma_grant_line_n,
    output addr, data_host, data_host_oe,
    input data_bus, input_acknowledge_n, dma_request_seen
  );
  modport card (
    input io_read_strobe_n, io_write_strobe_n, card_enable_n,
    input task_file_select_n, control_block_select_n, dma_grant_line_n,
    input addr, data_bus,
    output data_card, data_card_oe, input_acknowledge_n,
    output dma_request_line, dma_request_oe
  );
endinterface

//--- hw/stream_fifo.sv
// small synchronous fifo with valid and ready on both sides
module stream_fifo #(
  parameter int WIDTH = cardio_pkg::DATA_W,
  parameter int DEPTH = cardio_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wptr_reg;
  logic [PW-1:0] rptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage has no reset; only the pointers and count carry state
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  // pointers wrap explicitly so depth need not be a power of two
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wptr_reg <= (wptr_reg == PW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg <= (rptr_reg == PW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule

//--- hw/host_end.sv
// host end of the parallel port: strobes, selects and DMA grant
module host_end #(
  parameter int DATA_W = cardio_pkg::DATA_W,
  parameter int ADDR_W = cardio_pkg::ADDR_W
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  card_bus_if.host bus,
  input wire cardio_pkg::card_mode_t host_mode,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire cardio_pkg::host_cmd_t cmd_kind,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic cmd_ctrl_block,
  input wire logic [DATA_W-1:0] cmd_wdata,
  output logic resp_valid,
  output logic [DATA_W-1:0] resp_data,
  output logic resp_acked
);
  typedef enum logic [5:0] {
    H_IDLE = 6'h01,
    H_WAITREQ = 6'h02,
    H_SETUP = 6'h04,
    H_STROBE = 6'h08,
    H_RECOVER = 6'h10,
    H_RELEASE = 6'h20
  } host_state_t;

  localparam int SW = DATA_W + 2;

  host_state_t state_reg;
  cardio_pkg::host_cmd_t kind_reg;
  logic [3:0] cnt_reg;
  logic [SW-1:0] sync1_reg;
  logic [SW-1:0] sync2_reg;
  logic [DATA_W-1:0] data_s;
  logic ack_s;
  logic req_s;
  logic is_dma;
  logic is_read;

  // card outputs pass two flops before use
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= {{DATA_W{1'b1}}, 2'h2};
      sync2_reg <= {{DATA_W{1'b1}}, 2'h2};
    end else begin
      sync1_reg <= {bus.data_bus, bus.input_acknowledge_n, bus.dma_request_seen};
      sync2_reg <= sync1_reg;
    end
  end

  assign data_s = sync2_reg[SW-1:2];
  assign ack_s = ~sync2_reg[1];
  assign req_s = sync2_reg[0];
  assign is_dma = (kind_reg == cardio_pkg::CMD_DMA_RD) ||
                  (kind_reg == cardio_pkg::CMD_DMA_WR);
  assign is_read = (kind_reg == cardio_pkg::CMD_REG_RD) ||
                   (kind_reg == cardio_pkg::CMD_DMA_RD);

  // one command per access; DMA moves one word per command
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= H_IDLE;
      kind_reg <= cardio_pkg::CMD_REG_RD;
      cnt_reg <= '0;
      cmd_ready <= 1'b1;
      resp_valid <= 1'b0;
      resp_data <= '0;
      resp_acked <= 1'b0;
      bus.io_read_strobe_n <= 1'b1;
      bus.io_write_strobe_n <= 1'b1;
      bus.card_enable_n <= 1'b1;
      bus.task_file_select_n <= 1'b1;
      bus.control_block_select_n <= 1'b1;
      bus.dma_grant_line_n <= 1'b1;
      bus.addr <= '0;
      bus.data_host <= '0;
      bus.data_host_oe <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
      case (state_reg)
        H_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_ready <= 1'b0;
            kind_reg <= cmd_kind;
            bus.addr <= cmd_addr;
            bus.data_host <= cmd_wdata;
            cnt_reg <= 4'(cardio_pkg::SETUP_CYC - 1);
            if (cmd_kind == cardio_pkg::CMD_DMA_RD || cmd_kind == cardio_pkg::CMD_DMA_WR) begin
              state_reg <= H_WAITREQ;
            end else begin
              bus.card_enable_n <= ~(host_mode == cardio_pkg::MODE_IO);
              bus.task_file_select_n <= ~(host_mode == cardio_pkg::MODE_DISK & ~cmd_ctrl_block);
              bus.control_block_select_n <= ~(host_mode == cardio_pkg::MODE_DISK & cmd_ctrl_block);
              bus.data_host_oe <= (cmd_kind == cardio_pkg::CMD_REG_WR);
              state_reg <= H_SETUP;
            end
          end
        end
        H_WAITREQ: begin
          if (req_s) begin
            bus.dma_grant_line_n <= 1'b0;
            bus.data_host_oe <= (kind_reg == cardio_pkg::CMD_DMA_WR);
            state_reg <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (cnt_reg == '0) begin
            bus.io_read_strobe_n <= ~is_read;
            bus.io_write_strobe_n <= is_read;
            cnt_reg <= 4'(cardio_pkg::STROBE_CYC - 1);
            state_reg <= H_STROBE;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        H_STROBE: begin
          if (cnt_reg == '0) begin
            bus.io_read_strobe_n <= 1'b1;
            bus.io_write_strobe_n <= 1'b1;
            if (is_read) begin
              // buffer opens on acknowledge only in card I/O register reads
              resp_acked <= (host_mode != cardio_pkg::MODE_IO) | is_dma | ack_s;
              resp_data <= ((host_mode != cardio_pkg::MODE_IO) | is_dma | ack_s) ?
                           data_s : '0;
            end else begin
              resp_acked <= 1'b1;
              resp_data <= '0;
            end
            cnt_reg <= 4'(cardio_pkg::RECOVER_CYC - 1);
            state_reg <= H_RECOVER;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        H_RECOVER: begin
          if (cnt_reg == '0) begin
            bus.data_host_oe <= 1'b0;
            bus.card_enable_n <= 1'b1;
            bus.task_file_select_n <= 1'b1;
            bus.control_block_select_n <= 1'b1;
            state_reg <= is_dma ? H_RELEASE : H_IDLE;
            resp_valid <= ~is_dma;
            cmd_ready <= ~is_dma;
          end else begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        H_RELEASE: begin
          // hold the grant until the card has dropped its request
          if (!req_s) begin
            bus.dma_grant_line_n <= 1'b1;
            resp_valid <= 1'b1;
            cmd_ready <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
        default: begin
          state_reg <= H_IDLE;
        end
      endcase
    end
  end
endmodule

//--- dv/cardio_assertions.sv
// concurrent checks on the card port wires between host end and card end
module cardio_assertions (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic io_read_strobe_n,
  input wire logic io_write_strobe_n,
  input wire logic card_enable_n,
  input wire logic task_file_select_n,
  input wire logic control_block_select_n,
  input wire logic dma_grant_line_n,
  input wire logic data_host_oe,
  input wire logic data_card_oe,
  input wire logic input_acknowledge_n,
  input wire logic dma_request_seen
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);

  // cycles since the read strobe was last seen low, saturating at 7
  logic [2:0] rd_age;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_age <= 3'h7;
    end else if (!io_read_strobe_n) begin
      rd_age <= 3'h0;
    end else if (rd_age != 3'h7) begin
      rd_age <= rd_age + 3'h1;
    end
  end

  // strobe pulses: eight cycles low, then released
  sequence rd_pulse_s;
    !io_read_strobe_n [*8] ##1 io_read_strobe_n;
  endsequence
  sequence wr_pulse_s;
    !io_write_strobe_n [*8] ##1 io_write_strobe_n;
  endsequence

  a_ack_needs_select: assert property (
    !input_acknowledge_n |-> (!card_enable_n || !$past(card_enable_n)))
    else $error("input acknowledge low without select");
  a_ack_follows_read: assert property (
    $fell(input_acknowledge_n) |-> (!io_read_strobe_n && !$past(io_read_strobe_n, 2)))
    else $error("input acknowledge without read strobe");
  // sync latency both ways leaves at most four cycles of drive after the strobe
  a_data_in_strobe: assert property (
    data_card_oe |-> rd_age <= 3'h4)
    else $error("card drives data outside read strobe");
  a_read_strobe_len: assert property (
    $fell(io_read_strobe_n) |-> rd_pulse_s)
    else $error("read strobe length wrong");
  a_write_strobe_len: assert property (
    $fell(io_write_strobe_n) |-> wr_pulse_s)
    else $error("write strobe length wrong");
  a_write_host_drives: assert property (
    !io_write_strobe_n |-> (data_host_oe && !data_card_oe))
    else $error("write data not driven by host");
  a_req_held_grant: assert property (
    $fell(dma_request_seen) |-> (!dma_grant_line_n && io_read_strobe_n && io_write_strobe_n))
    else $error("request dropped before grant and strobe");
  a_req_rearm_gap: assert property (
    $rose(dma_request_seen) |-> $past(dma_grant_line_n))
    else $error("request raised while grant still low");
  a_grant_on_request: assert property (
    $fell(dma_grant_line_n) |-> dma_request_seen)
    else $error("grant given without request");
  a_grant_release: assert property (
    $rose(dma_grant_line_n) |-> !dma_request_seen)
    else $error("grant released while request high");
  a_selects_in_dma: assert property (
    !dma_grant_line_n |-> (task_file_select_n && control_block_select_n))
    else $error("select asserted during DMA");
endmodule

//--- dv/card_io_read_and_dma_request_tb_top.sv
// self-checking bench: host end and card end joined over the port
module card_io_read_and_dma_request_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  cardio_pkg::card_mode_t card_mode = cardio_pkg::MODE_IO;
  logic dev_selected = 1'b1;
  logic [15:0] reg_rdata = 16'h0000;
  logic [3:0] reg_addr;
  logic reg_wr_valid;
  logic [15:0] reg_wr_data;
  logic dma_start = 1'b0;
  logic dma_to_host = 1'b0;
  logic [15:0] dma_words = 16'h0000;
  logic dma_busy;
  logic rd_valid;
  logic [15:0] rd_data;
  logic rd_taken;
  logic wr_valid;
  logic [15:0] wr_data;
  logic wr_ready = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  cardio_pkg::host_cmd_t cmd_kind = cardio_pkg::CMD_REG_RD;
  logic [3:0] cmd_addr = 4'h0;
  logic cmd_ctrl_block = 1'b0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic resp_valid;
  logic [15:0] resp_data;
  logic resp_acked;
  int err_count = 0;
  int n_checks = 0;
  int rd_idx = 0;
  int wr_cnt = 0;
  logic [15:0] wr_last;
  logic [3:0] addr_last;
  logic [15:0] got_q[$];
  logic [15:0] rd_words [3] = '{16'hA5C3, 16'h0001, 16'hFFFE};

  card_bus_if card_bus_if_i ();
  host_end host_end_i (.clk_sys, .rst_b, .bus(card_bus_if_i), .host_mode(card_mode),
    .cmd_valid, .cmd_ready, .cmd_kind, .cmd_addr, .cmd_ctrl_block, .cmd_wdata,
    .resp_valid, .resp_data, .resp_acked);
  card_end card_end_i (.clk_sys, .rst_b, .bus(card_bus_if_i), .card_mode, .dev_selected,
    .reg_rdata, .reg_addr, .reg_wr_valid, .reg_wr_data, .dma_start, .dma_to_host,
    .dma_words, .dma_busy, .rd_valid, .rd_data, .rd_taken, .wr_valid, .wr_data, .wr_ready);
  cardio_assertions cardio_assertions_i (.clk_sys, .rst_b,
    .io_read_strobe_n(card_bus_if_i.io_read_strobe_n),
    .io_write_strobe_n(card_bus_if_i.io_write_strobe_n),
    .card_enable_n(card_bus_if_i.card_enable_n),
    .task_file_select_n(card_bus_if_i.task_file_select_n),
    .control_block_select_n(card_bus_if_i.control_block_select_n),
    .dma_grant_line_n(card_bus_if_i.dma_grant_line_n),
    .data_host_oe(card_bus_if_i.data_host_oe), .data_card_oe(card_bus_if_i.data_card_oe),
    .input_acknowledge_n(card_bus_if_i.input_acknowledge_n),
    .dma_request_seen(card_bus_if_i.dma_request_seen));

  // clock at 25 MHz
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // card-to-host words, advanced on each take; runs dry after three
  assign rd_valid = (rd_idx < 3);
  assign rd_data = rd_words[rd_idx % 3];
  // monitors of the card's user side
  always @(posedge clk_sys) begin
    if (rd_taken === 1'b1) rd_idx <= rd_idx + 1;
    if (wr_valid === 1'b1 && wr_ready === 1'b1) got_q.push_back(wr_data);
    if (reg_wr_valid === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_last <= reg_wr_data;
      addr_last <= reg_addr;
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic hang(input string what);
    err_count++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    wrap_up();
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // one host command; address bit 3 picks the control block select
  task automatic do_cmd(input cardio_pkg::host_cmd_t k, input logic [3:0] a,
                        input logic [15:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1) begin
      @(negedge clk_sys);
      if (++n > 300) hang("cmd_ready");
    end
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_ctrl_block <= a[3];
    cmd_wdata <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_sys);
      if (++n > 300) hang("resp_valid");
    end while (resp_valid !== 1'b1);
  endtask

  task automatic set_mode(input cardio_pkg::card_mode_t m, input logic [15:0] rdata);
    @(posedge clk_sys);
    card_mode <= m;
    reg_rdata <= rdata;
    cycles(4);
  endtask

  // register write, then a fixed wait so a late or stray pulse is still counted
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d, input int exp_cnt,
                           input logic [15:0] exp_d);
    do_cmd(cardio_pkg::CMD_REG_WR, a, d);
    cycles(4);
    chk("reg write count", 16'(exp_cnt), 16'(wr_cnt));
    if (exp_cnt != 0) chk("reg write data", exp_d, wr_last);
  endtask

  task automatic t_io();
    set_mode(cardio_pkg::MODE_IO, 16'hC35A);
    do_cmd(cardio_pkg::CMD_REG_RD, 4'h2, 16'h0000);
    chk("io read data", 16'hC35A, resp_data);
    chk("io read acked", 16'h0001, {15'h0000, resp_acked});
    chk("ack idle", 16'h0001, {15'h0000, card_bus_if_i.input_acknowledge_n});
    reg_write(4'h5, 16'h8001, 1, 16'h8001);
    chk("reg write addr", 16'h0005, {12'h000, addr_last});
  endtask

  // memory mode: strobes run but the card must not answer them
  // host needs no acknowledge outside io mode, so only idle data comes back
  task automatic t_mem();
    set_mode(cardio_pkg::MODE_MEMORY, 16'h1234);
    do_cmd(cardio_pkg::CMD_REG_RD, 4'h2, 16'h0000);
    chk("memory read data", 16'hFFFF, resp_data);
    chk("memory read acked", 16'h0001, {15'h0000, resp_acked});
    chk("memory ack idle", 16'h0001, {15'h0000, card_bus_if_i.input_acknowledge_n});
    reg_write(4'h3, 16'h5555, 1, 16'h8001);
  endtask

  task automatic t_disk_reg();
    set_mode(cardio_pkg::MODE_DISK, 16'hBE7F);
    do_cmd(cardio_pkg::CMD_REG_RD, 4'h1, 16'h0000);
    chk("disk read data", 16'h007F, resp_data);
    do_cmd(cardio_pkg::CMD_REG_RD, 4'hE, 16'h0000);
    chk("ctrl read data", 16'h007F, resp_data);
    reg_write(4'h7, 16'hAB12, 2, 16'h0012);
    @(posedge clk_sys);
    dev_selected <= 1'b0;
    cycles(4);
    chk("request oe off", 16'h0000, {15'h0000, card_bus_if_i.dma_request_oe});
    @(posedge clk_sys);
    dev_selected <= 1'b1;
    cycles(4);
    chk("request oe on", 16'h0001, {15'h0000, card_bus_if_i.dma_request_oe});
  endtask

  task automatic start_dma(input logic to_host, input logic [15:0] words);
    @(posedge clk_sys);
    dma_start <= 1'b1;
    dma_to_host <= to_host;
    dma_words <= words;
    @(posedge clk_sys);
    dma_start <= 1'b0;
  endtask

  task automatic t_dma_rd();
    start_dma(1'b1, 16'h0003);
    for (int i = 0; i < 3; i++) begin
      do_cmd(cardio_pkg::CMD_DMA_RD, 4'h0, 16'h0000);
      chk("dma read word", rd_words[i], resp_data);
    end
    cycles(10);
    chk("dma busy after read", 16'h0000, {15'h0000, dma_busy});
  endtask

  // fifo full with the sink stalled: the card must stop asking for words
  task automatic t_dma_wr();
    int n;
    start_dma(1'b0, 16'h000A);
    for (int i = 0; i < 8; i++) do_cmd(cardio_pkg::CMD_DMA_WR, 4'h0, 16'h1000 + 16'(i));
    n = 0;
    repeat (30) begin
      @(negedge clk_sys);
      if (card_bus_if_i.dma_request_seen === 1'b1) n++;
    end
    chk("request while full", 16'h0000, 16'(n));
    @(posedge clk_sys);
    wr_ready <= 1'b1;
    for (int i = 8; i < 10; i++) do_cmd(cardio_pkg::CMD_DMA_WR, 4'h0, 16'h1000 + 16'(i));
    for (n = 0; n < 50 && got_q.size() < 10; n++) @(negedge clk_sys);
    chk("dma write words", 16'h000A, 16'(got_q.size()));
    foreach (got_q[i]) chk("dma write word", 16'h1000 + 16'(i), got_q[i]);
  endtask

  // main sequence: 12 cycles of reset, then every scenario in turn
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    cycles(2);
    chk("cmd_ready after reset", 16'h0001, {15'h0000, cmd_ready});
    chk("request after reset", 16'h0000, {15'h0000, card_bus_if_i.dma_request_seen});
    t_io();
    t_mem();
    t_disk_reg();
    t_dma_rd();
    t_dma_wr();
    wrap_up();
  end
endmodule
